// >>> design/rx_port_equalizer_control.v
// Per-port equalizer control bank of a two-port deserializer, with its adaptation engine.
// Assumes a byte-wide register port from the I2C target and 10 MHz core clock.
`timescale 1ns/1ps
`include "rx_eq_map.vh"
module rx_port_equalizer_control #(
   parameter [23:0] WAIT_CYC_0 = `WAIT_CYC_0,
   parameter [23:0] WAIT_CYC_1 = `WAIT_CYC_1,
   parameter [23:0] WAIT_CYC_2 = `WAIT_CYC_2,
   parameter [23:0] WAIT_CYC_3 = `WAIT_CYC_3,
   parameter [23:0] WAIT_CYC_4 = `WAIT_CYC_4,
   parameter [23:0] WAIT_CYC_5 = `WAIT_CYC_5,
   parameter [23:0] WAIT_CYC_6 = `WAIT_CYC_6,
   parameter [23:0] WAIT_CYC_7 = `WAIT_CYC_7
) (
   input wire clk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   input wire [1:0] lock_detect,
   input wire [1:0] remote_selftest_active,
   input wire [1:0] bc_frame_start,
   output wire [1:0] bc_bit_flip,
   output wire [11:0] eq_setting,
   output wire [1:0] rx_lock
);
   localparam [1:0] ST_START = 2'h0;
   localparam [1:0] ST_WAIT = 2'h1;
   localparam [1:0] ST_DONE = 2'h2;

   reg port_sel_ff;
   reg [7:0] spare_bf_ff;
   reg [7:0] rdata_ff;
   reg [7:0] nxt_rdata;
   wire [15:0] port_rd_bus;
   wire wr_shared;

   assign reg_rdata = rdata_ff;
   assign wr_shared = reg_wr;

   always @(posedge clk) begin
      if (!nrst) begin
         port_sel_ff <= `RST_PORT_SEL;
         spare_bf_ff <= `RST_SPARE_BF;
      end else if (wr_shared) begin
         if (reg_addr == `REG_PORT_SEL) begin
            port_sel_ff <= reg_wdata[`PS_PORT];
         end
         if (reg_addr == `REG_SPARE_BF) begin
            spare_bf_ff <= reg_wdata;
         end
      end
   end

   genvar p;
   generate
      for (p = 0; p < `NUM_PORTS; p = p + 1) begin : g_port
         // Port index as one bit, to match the port-select register
         localparam [0:0] PIDX = (p == 1) ? 1'b1 : 1'b0;
         reg [7:0] link_test_ff;
         reg [7:0] adapt_ctl_ff;
         reg [7:0] manual_ff;
         reg [7:0] limits_ff;
         reg restart_ff;
         reg selftest_ff;
         reg [1:0] state_ff;
         reg [5:0] gain_ff;
         reg [5:0] applied_ff;
         reg first_seen_ff;
         reg lock_ff;
         reg [1:0] nxt_state;
         reg [5:0] nxt_gain;
         reg [5:0] nxt_applied;
         reg nxt_first;
         reg nxt_lock;
         reg timer_go;
         reg [7:0] rd_p;
         wire wr_here;
         wire arm_once;
         wire expire;
         wire bypass;
         wire first_mode;
         wire floor_en;
         wire lock_mode;
         wire [5:0] ceil6;
         wire [5:0] start_gain;
         wire [5:0] start_clamped;
         wire [5:0] manual6;

         // Only the selected port's copy sees a write
         assign wr_here = reg_wr & (port_sel_ff == PIDX);
         // Each write with the once bit set arms a single flip
         assign arm_once = wr_here & (reg_addr == `REG_LINK_TEST) &
                           reg_wdata[`LT_INJ_ONCE];

         assign bypass = manual_ff[`MO_BYPASS];
         assign lock_mode = manual_ff[`MO_LOCKMODE];
         assign first_mode = adapt_ctl_ff[`AC_FIRST];
         assign floor_en = adapt_ctl_ff[`AC_FLOOR];
         assign ceil6 = {2'b00, limits_ff[`LM_CEIL_HI:`LM_CEIL_LO]};
         assign start_gain = floor_en ?
                             {2'b00, limits_ff[`LM_FLOOR_HI:`LM_FLOOR_LO]} :
                             6'h00;
         // A floor above the ceiling is a host slip; the ceiling still holds
         assign start_clamped = (start_gain > ceil6) ? ceil6 : start_gain;
         assign manual6 = {manual_ff[`MO_UPPER_HI:`MO_UPPER_LO],
                           manual_ff[`MO_LOWER_HI:`MO_LOWER_LO]};

         always @(posedge clk) begin
            if (!nrst) begin
               link_test_ff <= `RST_LINK_TEST;
               adapt_ctl_ff <= `RST_ADAPT_CTL;
               manual_ff <= `RST_MANUAL;
               limits_ff <= `RST_LIMITS;
               restart_ff <= 1'b0;
               selftest_ff <= 1'b0;
            end else begin
               selftest_ff <= remote_selftest_active[p];
               // Self-clearing: a pulse lasting one cycle
               restart_ff <= wr_here & (reg_addr == `REG_ADAPT_CTL) &
                             reg_wdata[`AC_RESTART];
               if (wr_here) begin
                  case (reg_addr)
                     `REG_LINK_TEST: link_test_ff <= reg_wdata & `WMASK_LINK_TEST;
                     `REG_ADAPT_CTL: adapt_ctl_ff <= reg_wdata & `WMASK_ADAPT_CTL;
                     `REG_MANUAL: manual_ff <= reg_wdata;
                     `REG_LIMITS: limits_ff <= reg_wdata;
                     default: link_test_ff <= link_test_ff;
                  endcase
               end
            end
         end

         // Count runs only in WAIT; a go or leaving WAIT clears it
         lock_wait_timer #(
            .C0(WAIT_CYC_0),
            .C1(WAIT_CYC_1),
            .C2(WAIT_CYC_2),
            .C3(WAIT_CYC_3),
            .C4(WAIT_CYC_4),
            .C5(WAIT_CYC_5),
            .C6(WAIT_CYC_6),
            .C7(WAIT_CYC_7)
         ) u_timer (
            .clk(clk),
            .nrst(nrst),
            .en(state_ff == ST_WAIT),
            .go(timer_go),
            .sel(adapt_ctl_ff[`AC_WAIT_HI:`AC_WAIT_LO]),
            .expire(expire)
         );

         bc_error_injector u_inject (
            .clk(clk),
            .nrst(nrst),
            .continuous(link_test_ff[`LT_INJ_CONT]),
            .arm_once(arm_once),
            .frame_start(bc_frame_start[p]),
            .bit_flip(bc_bit_flip[p])
         );

         // Restart forgets the first lock, so first-lock mode applies again
         always @* begin
            nxt_state = state_ff;
            nxt_gain = gain_ff;
            nxt_first = first_seen_ff;
            timer_go = 1'b0;
            if (restart_ff || bypass) begin
               nxt_state = ST_START;
               if (restart_ff) begin
                  nxt_first = 1'b0;
               end
            end else begin
               case (state_ff)
                  ST_START: begin
                     nxt_gain = start_clamped;
                     timer_go = 1'b1;
                     nxt_state = ST_WAIT;
                  end
                  ST_WAIT: begin
                     if (lock_detect[p]) begin
                        if (first_mode && !first_seen_ff) begin
                           nxt_first = 1'b1;
                           nxt_gain = 6'h00;
                           timer_go = 1'b1;
                        end else begin
                           nxt_first = 1'b1;
                           nxt_state = ST_DONE;
                        end
                     end else if (expire) begin
                        if (gain_ff >= ceil6) begin
                           nxt_gain = start_clamped;
                        end else begin
                           nxt_gain = gain_ff + 6'h01;
                        end
                     end else if (gain_ff > ceil6) begin
                        // Ceiling lowered mid-wait: pull the gain down at once
                        nxt_gain = ceil6;
                     end
                  end
                  ST_DONE: begin
                     if (!lock_detect[p]) begin
                        nxt_state = ST_START;
                     end
                  end
                  default: begin
                     nxt_state = ST_START;
                  end
               endcase
            end
         end

         always @* begin
            if (bypass) begin
               nxt_applied = manual6;
            end else if (gain_ff > ceil6) begin
               nxt_applied = ceil6;
            end else begin
               nxt_applied = gain_ff;
            end
            // Bypass has nothing to adapt, so it counts as complete
            nxt_lock = lock_detect[p] &
                       (~lock_mode | bypass | (state_ff == ST_DONE));
         end

         always @(posedge clk) begin
            if (!nrst) begin
               state_ff <= ST_START;
               gain_ff <= 6'h00;
               applied_ff <= 6'h00;
               first_seen_ff <= 1'b0;
               lock_ff <= 1'b0;
            end else begin
               state_ff <= nxt_state;
               gain_ff <= nxt_gain;
               applied_ff <= nxt_applied;
               first_seen_ff <= nxt_first;
               lock_ff <= nxt_lock;
            end
         end

         always @* begin
            case (reg_addr)
               `REG_LINK_TEST: rd_p = {link_test_ff[7:6], selftest_ff,
                                       link_test_ff[4:0]};
               `REG_ADAPT_CTL: rd_p = {adapt_ctl_ff[7:4], restart_ff,
                                       adapt_ctl_ff[2], 2'b00};
               `REG_LEVEL: rd_p = {2'b00, applied_ff};
               `REG_MANUAL: rd_p = manual_ff;
               `REG_LIMITS: rd_p = limits_ff;
               default: rd_p = 8'h00;
            endcase
         end

         // Each port drives its own byte; the shared mux below picks one
         assign port_rd_bus[8*p +: 8] = rd_p;
         assign eq_setting[6*p +: 6] = applied_ff;
         assign rx_lock[p] = lock_ff;
      end
   endgenerate

   // Read data registered, so it holds between read strobes
   always @* begin
      case (reg_addr)
         `REG_PORT_SEL: nxt_rdata = {7'h00, port_sel_ff};
         `REG_SPARE_BF: nxt_rdata = spare_bf_ff;
         `REG_SPARE_D1: nxt_rdata = `VAL_SPARE_D1;
         `REG_LINK_TEST,
         `REG_ADAPT_CTL,
         `REG_LEVEL,
         `REG_MANUAL,
         `REG_LIMITS: nxt_rdata = port_sel_ff ? port_rd_bus[15:8] :
                                               port_rd_bus[7:0];
         default: nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (!nrst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end
   end
endmodule // rx_port_equalizer_control

// >>> design/rx_eq_map.vh
// Offsets, field positions, reset values and wait counts of the equalizer control bank.
// Assumes a 10 MHz core clock; included only by the top design file of the bank.
`ifndef RX_EQ_MAP_VH
`define RX_EQ_MAP_VH

`define NUM_PORTS 2

`define REG_PORT_SEL 8'h4C
`define REG_SPARE_BF 8'hBF
`define REG_LINK_TEST 8'hD0
`define REG_SPARE_D1 8'hD1
`define REG_ADAPT_CTL 8'hD2
`define REG_LEVEL 8'hD3
`define REG_MANUAL 8'hD4
`define REG_LIMITS 8'hD5

`define RST_PORT_SEL 1'b0
`define RST_SPARE_BF 8'h00
`define VAL_SPARE_D1 8'h43
`define RST_LINK_TEST 8'h00
`define RST_ADAPT_CTL 8'h94
`define RST_MANUAL 8'h60
`define RST_LIMITS 8'hF2

`define WMASK_LINK_TEST 8'hDF
`define WMASK_ADAPT_CTL 8'hF4

`define PS_PORT 0
`define LT_SELFTEST 5
`define LT_INJ_CONT 1
`define LT_INJ_ONCE 0
`define AC_WAIT_HI 7
`define AC_WAIT_LO 5
`define AC_FIRST 4
`define AC_RESTART 3
`define AC_FLOOR 2
`define MO_UPPER_HI 7
`define MO_UPPER_LO 5
`define MO_LOCKMODE 4
`define MO_LOWER_HI 3
`define MO_LOWER_LO 1
`define MO_BYPASS 0
`define LM_CEIL_HI 7
`define LM_CEIL_LO 4
`define LM_FLOOR_HI 3
`define LM_FLOOR_LO 0

`define CLK_PERIOD_NS 100
`define WAIT_T0_NS 164000
`define WAIT_T1_NS 328000
`define WAIT_T2_NS 655000
`define WAIT_T3_NS 1310000
`define WAIT_T4_NS 2620000
`define WAIT_T5_NS 5240000
`define WAIT_T6_NS 10500000
`define WAIT_T7_NS 21000000
// Waits above in whole core clock periods, sized to the timer's count
`define WAIT_CYC_0 24'h000668
`define WAIT_CYC_1 24'h000CD0
`define WAIT_CYC_2 24'h001996
`define WAIT_CYC_3 24'h00332C
`define WAIT_CYC_4 24'h006658
`define WAIT_CYC_5 24'h00CCB0
`define WAIT_CYC_6 24'h019A28
`define WAIT_CYC_7 24'h033450

`endif

// >>> design/lock_wait_timer.v
// Lock wait timer: counts the selected wait period while enabled, pulses on expiry.
// Assumes go restarts the count; reloads by itself after each expiry.
`timescale 1ns/1ps
module lock_wait_timer #(
   parameter [23:0] C0 = 24'h000668,
   parameter [23:0] C1 = 24'h000CD0,
   parameter [23:0] C2 = 24'h001996,
   parameter [23:0] C3 = 24'h00332C,
   parameter [23:0] C4 = 24'h006658,
   parameter [23:0] C5 = 24'h00CCB0,
   parameter [23:0] C6 = 24'h019A28,
   parameter [23:0] C7 = 24'h033450
) (
   input wire clk,
   input wire nrst,
   input wire en,
   input wire go,
   input wire [2:0] sel,
   output wire expire
);
   reg [23:0] cnt_ff;
   reg [23:0] lim;
   wire at_end;

   always @* begin
      case (sel)
         3'h0: lim = C0;
         3'h1: lim = C1;
         3'h2: lim = C2;
         3'h3: lim = C3;
         3'h4: lim = C4;
         3'h5: lim = C5;
         3'h6: lim = C6;
         default: lim = C7;
      endcase
   end

   // A shortened selection mid-count still ends at once, never wraps
   assign at_end = (cnt_ff >= (lim - 24'h000001));
   assign expire = en & ~go & at_end;

   always @(posedge clk) begin
      if (!nrst || go || !en || at_end) begin
         cnt_ff <= 24'h000000;
      end else begin
         cnt_ff <= cnt_ff + 24'h000001;
      end
   end
endmodule // lock_wait_timer

// >>> design/bc_error_injector.v
// Back-channel error injector: marks outgoing frames whose one bit is to be flipped.
// Assumes frame_start pulses once per outgoing frame from the back-channel framer.
`timescale 1ns/1ps
module bc_error_injector (
   input wire clk,
   input wire nrst,
   input wire continuous,
   input wire arm_once,
   input wire frame_start,
   output wire bit_flip
);
   reg armed_ff;
   wire nxt_armed;

   assign bit_flip = frame_start & (continuous | armed_ff);
   // A new arm in the consuming cycle survives for the next frame
   assign nxt_armed = arm_once | (armed_ff & ~frame_start);

   always @(posedge clk) begin
      if (!nrst) begin
         armed_ff <= 1'b0;
      end else begin
         armed_ff <= nxt_armed;
      end
   end
endmodule // bc_error_injector

// >>> tb/remote_serializer_model.sv
// Remote serializer stand-in: back-channel frame starts and self-test report.
// Assumes the bench requests self test per port; moves only on the rising edge.
`timescale 1ns/1ps
module remote_serializer_model #(
   parameter integer FRAME_GAP = 6
) (
   input wire clk,
   input wire nrst,
   input wire [1:0] selftest_req,
   output reg [1:0] remote_selftest_active = 2'b00,
   output reg [1:0] bc_frame_start = 2'b00
);
   integer cnt = 0;
   always @(posedge clk) begin
      remote_selftest_active <= selftest_req;
      cnt <= (!nrst || cnt == FRAME_GAP - 1) ? 0 : cnt + 1;
      // Ports staggered so a flip on the wrong port shows up
      bc_frame_start <= {cnt == 2, cnt == 0} & {2{nrst}};
   end
endmodule // remote_serializer_model

// >>> tb/eq_bank_chk_sva.sv
// Checker for the equalizer control bank, watching its top ports only.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module eq_bank_chk (
   input wire clk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [1:0] lock_detect,
   input wire [1:0] remote_selftest_active,
   input wire [1:0] bc_frame_start,
   input wire [1:0] bc_bit_flip,
   input wire [11:0] eq_setting,
   input wire [1:0] rx_lock
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   flip_in_frame_a: assert property ((bc_bit_flip & ~bc_frame_start) == 2'b00)
      else $error("bit flip outside a frame start");
   lock_needs_det_a: assert property (rx_lock != 2'b00 |-> (rx_lock & ~$past(lock_detect)) == 2'b00)
      else $error("lock reported without detector lock");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   level_top_zero_a: assert property (reg_rd && reg_addr == 8'hD3 |=> reg_rdata[7:6] == 2'b00)
      else $error("level status top bits set");
   unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   spare_fixed_a: assert property (reg_rd && reg_addr == 8'hD1 |=> reg_rdata == 8'h43)
      else $error("fixed spare byte wrong");
   selftest_flag_a: assert property (reg_rd && reg_addr == 8'hD0 &&
      !(^$past(remote_selftest_active)) |=>
      reg_rdata[5] == $past(remote_selftest_active[0], 2))
      else $error("self test flag wrong");
   restart_clear_a: assert property (reg_wr && reg_addr == 8'hD2 ##1 !reg_rd ##1
      reg_rd && reg_addr == 8'hD2 |=> reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'b00)
      else $error("restart bit did not clear");
endmodule // eq_bank_chk
bind rx_port_equalizer_control eq_bank_chk chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .lock_detect(lock_detect), .remote_selftest_active(remote_selftest_active),
   .bc_frame_start(bc_frame_start), .bc_bit_flip(bc_bit_flip), .eq_setting(eq_setting),
   .rx_lock(rx_lock));

// >>> tb/rx_port_equalizer_control_bench.sv
// Self-checking bench for the equalizer control bank with shortened lock waits.
// Assumes the remote serializer model supplies frame starts and self-test flags.
`timescale 1ns/1ps
module rx_port_equalizer_control_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] lock_detect = 2'b00;
   logic [1:0] st_req = 2'b00;
   wire [7:0] reg_rdata;
   wire [1:0] sta, frm, flip, rx_lock;
   wire [11:0] eq_setting;
   logic [15:0] q[$];
   logic [15:0] note;
   logic rd_seen = 1'b0;
   integer n_fail = 0;
   integer compares = 0;
   integer seed = 84;
   integer nf [0:1] = '{0, 0};
   integer nb [0:1] = '{0, 0};
   integer i, c, f0, b0;
   logic [7:0] v;
   logic [5:0] lo, hi, lo1, hi1;
   localparam logic [7:0] RA [0:7] = '{8'h4C, 8'hBF, 8'hD0, 8'hD1, 8'hD2, 8'hD4, 8'hD5, 8'h10};
   localparam logic [7:0] RV [0:7] = '{8'h00, 8'h00, 8'h00, 8'h43, 8'h94, 8'h60, 8'hF2, 8'h00};

   // Codes 0 to 4 shortened to 4+sel cycles; codes 5 to 7 keep their real length
   rx_port_equalizer_control #(.WAIT_CYC_0(24'h4), .WAIT_CYC_1(24'h5), .WAIT_CYC_2(24'h6),
      .WAIT_CYC_3(24'h7), .WAIT_CYC_4(24'h8)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .lock_detect(lock_detect), .remote_selftest_active(sta), .bc_frame_start(frm),
      .bc_bit_flip(flip), .eq_setting(eq_setting), .rx_lock(rx_lock));
   remote_serializer_model ser (.clk(clk), .nrst(nrst), .selftest_req(st_req),
      .remote_selftest_active(sta), .bc_frame_start(frm));

   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      rd_seen <= reg_rd;
      for (int p = 0; p < 2; p++) begin
         nf[p] <= nf[p] + frm[p];
         nb[p] <= nb[p] + flip[p];
      end
   end
   always @(negedge clk) begin
      if (rd_seen && q.size() > 0) begin
         note = q.pop_front();
         check("read data", reg_rdata & note[7:0], note[15:8]);
      end
   end

   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge clk);
      q.push_back({e & m, m});
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
   endtask
   task print_verdict();
      $display("checks %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task wait_step();
      logic [5:0] g;
      g = eq_setting[5:0];
      c = 0;
      while (eq_setting[5:0] === g && c < 200) begin
         @(negedge clk);
         c = c + 1;
      end
      if (c == 200) begin
         n_fail = n_fail + 1;
         print_verdict();
      end
   endtask

   initial begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      for (i = 0; i < 8; i++) rd(RA[i], RV[i], 8'hFF);
      wr(8'hD0, 8'h01);
      f0 = nb[0];
      b0 = nb[1];
      repeat (30) @(negedge clk);
      check("single flips", 8'(nb[0] - f0), 8'h01);
      check("other port flips", 8'(nb[1] - b0), 8'h00);
      wr(8'hD0, 8'h02);
      f0 = nf[0];
      b0 = nb[0];
      repeat (30) @(negedge clk);
      check("continuous flips", 8'(nb[0] - b0), 8'(nf[0] - f0));
      wr(8'hD0, 8'hFF);
      // Flag passes the model's register and the bank's before it reads back
      st_req = 2'b01;
      repeat (2) @(negedge clk);
      rd(8'hD0, 8'hFF, 8'hFF);
      st_req = 2'b10;
      repeat (2) @(negedge clk);
      rd(8'hD0, 8'hDF, 8'hFF);
      wr(8'hD0, 8'h00);
      st_req = 2'b00;
      wr(8'hD2, 8'hFF);
      rd(8'hD2, 8'hF4, 8'hFF);
      wr(8'hD1, 8'h00);
      rd(8'hD1, 8'h43, 8'hFF);
      wr(8'h4C, 8'h01);
      wr(8'hD5, 8'h83);
      rd(8'hD5, 8'h83, 8'hFF);
      rd(8'h4C, 8'h01, 8'hFF);
      wr(8'h4C, 8'h00);
      rd(8'hD5, 8'hF2, 8'hFF);
      for (i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         wr(8'hD4, v | 8'h01);
         rd(8'hD3, {2'b00, v[7:5], v[3:1]}, 8'hFF);
         check("manual setting", {2'b00, eq_setting[5:0]}, {2'b00, v[7:5], v[3:1]});
         v = 8'($random(seed));
         wr(8'hD5, {1'b1, v[6:4], 1'b0, v[2:0]});
         rd(8'hD5, {1'b1, v[6:4], 1'b0, v[2:0]}, 8'hFF);
      end
      wr(8'hD4, 8'h60);
      wr(8'hD5, 8'hF2);
      // Third interval only: the first may still run on the old code
      for (i = 0; i < 5; i++) begin
         wr(8'hD2, {i[2:0], 5'h04});
         repeat (3) wait_step();
         check("step interval", 8'(c), 8'(4 + i));
      end
      // Code 5 waits far longer than this window, so the gain must sit still
      wr(8'hD2, 8'hA4);
      @(negedge clk);
      lo = eq_setting[5:0];
      repeat (40) @(negedge clk);
      check("long wait hold", {2'b00, eq_setting[5:0]}, {2'b00, lo});
      wr(8'hD2, 8'h04);
      wr(8'hD5, 8'h42);
      lo = 6'h3F;
      hi = 6'h00;
      lo1 = 6'h3F;
      hi1 = 6'h00;
      repeat (60) begin
         @(negedge clk);
         if (eq_setting[5:0] < lo) lo = eq_setting[5:0];
         if (eq_setting[5:0] > hi) hi = eq_setting[5:0];
         if (eq_setting[11:6] < lo1) lo1 = eq_setting[11:6];
         if (eq_setting[11:6] > hi1) hi1 = eq_setting[11:6];
      end
      check("lowest gain", {2'b00, lo}, 8'h02);
      check("highest gain", {2'b00, hi}, 8'h04);
      // Port 1 still runs on its own limits 0x83 from earlier
      check("port 1 lowest gain", {2'b00, lo1}, 8'h03);
      check("port 1 highest gain", {2'b00, hi1}, 8'h08);
      wr(8'hD4, 8'h10);
      wr(8'hD2, 8'h1C);
      repeat (2) @(negedge clk);
      lock_detect = 2'b11;
      repeat (2) @(negedge clk);
      check("early lock", {6'h00, rx_lock}, 8'h02);
      c = 0;
      while (rx_lock[0] !== 1'b1 && c < 20) begin
         @(negedge clk);
         c = c + 1;
      end
      if (c == 20) begin
         n_fail = n_fail + 1;
         print_verdict();
      end
      check("late lock", {6'h00, rx_lock}, 8'h03);
      check("locked gain", {2'b00, eq_setting[5:0]}, 8'h00);
      lock_detect = 2'b00;
      @(negedge clk);
      check("lock loss", {6'h00, rx_lock}, 8'h00);
      print_verdict();
   end
endmodule // rx_port_equalizer_control_bench
